// >>> verilog/redriver_consts.svh
`ifndef REDRIVER_CONSTS_SVH
`define REDRIVER_CONSTS_SVH

// software register byte offsets
`define REG_STATUS        8'h00
`define REG_MASK          8'h04
`define REG_CTRL          8'h08
`define REG_STATE         8'h0C
`define REG_CH_BASE       8'h10

// control and state field positions
`define CTRL_RELOAD       0
`define STATE_MODE_LSB    0
`define STATE_LOW_POWER   2
`define STATE_LOAD_DONE   3
`define STATE_LOADING     4

// event bits of status and mask
`define EV_LOAD_PASS      0
`define EV_LOAD_FAIL      1
`define EV_HOST_WRITE     2
`define EV_CABLE_CHANGE   3
`define EV_WIDTH          4

// channel setting byte layout
`define NUM_CH            4
`define CH_EQ_LSB         0
`define CH_GAIN_LSB       4
`define CH_DEFAULT        8'h00

// serial bus addresses
`define SLAVE_ADDR_HI     4'h4
`define EE_DEV_ADDR       7'h50
`define EE_FIRST_OFFSET   8'h00

// eeprom load sequence step numbers
`define STEP_RESTART      4'h3
`define STEP_FIRST_READ   4'h5
`define STEP_LAST_READ    4'h8
`define STEP_STOP         4'h9

// timing: eeprom serial clock derived from the system clock
`define SYS_CLK_PERIOD_NS 10
`define EE_SCL_PERIOD_NS  10000
`define EE_QUARTER_CYCLES ((`EE_SCL_PERIOD_NS + 4 * `SYS_CLK_PERIOD_NS - 1) / (4 * `SYS_CLK_PERIOD_NS))

// pin synchroniser reset value follows the pad pull-ups
`define PIN_SYNC_RESET    10'h027F

`endif

// >>> verilog/redriver_pkg.sv
package redriver_pkg;

	typedef enum logic [1:0] {
		MODE_PIN    = 2'b00,
		MODE_SLAVE  = 2'b01,
		MODE_MASTER = 2'b11
	} mode_e;

	typedef enum logic [2:0] {
		SL_IDLE = 3'b000,
		SL_ADDR = 3'b001,
		SL_PTR  = 3'b011,
		SL_WR   = 3'b010,
		SL_RD   = 3'b110
	} slave_state_e;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_RUN  = 2'b01,
		MS_DONE = 2'b11
	} master_state_e;

	typedef enum logic [1:0] {
		K_START = 2'b00,
		K_WRITE = 2'b01,
		K_READ  = 2'b11,
		K_STOP  = 2'b10
	} xfer_kind_e;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

	typedef struct packed {
		logic       cable_present_n;
		logic       config_source_select;
		logic       config_source_floating;
		logic [2:0] equalizer_strap;
		logic       gain_bit1_or_reg_reset_n;
		logic       gain_bit0_strap;
		logic       scl_in;
		logic       sda_in;
	} pin_in_s;

	typedef struct packed {
		logic [2:0] eq;
		logic [1:0] gain;
	} ch_setting_s;

endpackage : redriver_pkg

// >>> verilog/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] stable
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// three stages; stage1 feeds only stage2
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a change counts only once the two late stages agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					stable[i] <= RESET_VAL[i];
				end else if (stage2[i] == stage3[i]) begin
					stable[i] <= stage3[i];
				end
			end
		end
	endgenerate

endmodule : pin_sync

// >>> verilog/redriver_config_source_control.sv
// Summary of operation
// - mode pin low: channel settings come from straps, serial writes ignored
// - mode pin high: channel settings come from host-written registers
// - mode pin floating: act as bus master, load settings from eeprom
// - drive serial clock only in eeprom master mode, otherwise slave input
// - cable-present high: cable absent, enter low power in any mode
// - cable-present low: channels enabled, normal operation
// - in pin mode the equalizer straps set boost for all channels
// - the address straps form low bits of own slave address
// - in pin mode shared gain/reset pin sets flat-gain bit one
// - outside pin mode low shared pin resets registers to defaults
// - in pin mode gain strap sets flat-gain bit zero
// - after eeprom load, done output low on fail, high on pass
`timescale 1ns/10ps
`include "redriver_consts.svh"
module redriver_config_source_control (
	input  wire logic                            sys_clk,
	input  wire logic                            sys_rst,
	input  wire redriver_pkg::reg_req_s          reg_req,
	output logic                          [31:0] reg_rdata,
	input  wire redriver_pkg::pin_in_s           pins,
	output logic                                 scl_out,
	output logic                                 scl_oe_n,
	output logic                                 sda_out,
	output logic                                 sda_oe_n,
	output redriver_pkg::ch_setting_s      [3:0] ch_setting,
	output logic                                 low_power,
	output logic                                 channel_enable,
	output logic                                 load_done,
	output logic                                 irq
);

	redriver_pkg::pin_in_s         pin_s;
	redriver_pkg::mode_e           mode;
	redriver_pkg::slave_state_e    sl_state;
	redriver_pkg::master_state_e   ms_state;
	redriver_pkg::xfer_kind_e      kind;
	logic                          scl_prev;
	logic                          sda_prev;
	logic                          cable_prev;
	logic                          scl_rise;
	logic                          scl_fall;
	logic                          start_det;
	logic                          stop_det;
	logic [3:0]                    sl_cnt;
	logic [7:0]                    sl_shift;
	logic [7:0]                    sl_ptr;
	logic                          sl_drive_low;
	logic                          sl_acking;
	logic                          sl_wr;
	logic [7:0]                    sl_rd_byte;
	logic [7:0]                    cfg [`NUM_CH];
	logic                          pending;
	logic [3:0]                    ms_step;
	logic [3:0]                    ms_bit;
	logic [1:0]                    ms_q;
	logic [7:0]                    ms_div;
	logic                          ms_fail;
	logic [7:0]                    ms_rx;
	logic                          ms_tick;
	logic                          ms_scl;
	logic                          ms_sda;
	logic [7:0]                    ms_tx;
	logic                          ee_wr;
	logic                          load_end;
	logic                          reload_wr;
	logic [`EV_WIDTH-1:0]          events;
	logic [`EV_WIDTH-1:0]          status;
	logic [`EV_WIDTH-1:0]          mask;

	// one synchroniser for every pad input, the serial clock among them
	pin_sync #(
		.WIDTH     (10),
		.RESET_VAL (`PIN_SYNC_RESET)
	) u_pin_sync (
		.sys_clk  (sys_clk),
		.sys_rst  (sys_rst),
		.async_in (pins),
		.stable   (pin_s)
	);

	// step number to action of the eeprom load sequence
	function automatic redriver_pkg::xfer_kind_e step_kind(input logic [3:0] step);
		if (step == 4'h0 || step == `STEP_RESTART) begin
			step_kind = redriver_pkg::K_START;
		end else if (step == `STEP_STOP) begin
			step_kind = redriver_pkg::K_STOP;
		end else if (step >= `STEP_FIRST_READ) begin
			step_kind = redriver_pkg::K_READ;
		end else begin
			step_kind = redriver_pkg::K_WRITE;
		end
	endfunction : step_kind

	// byte sent by a write step: device address, offset, address for read
	function automatic logic [7:0] step_byte(input logic [3:0] step);
		if (step == 4'h1) begin
			step_byte = {`EE_DEV_ADDR, 1'b0};
		end else if (step == 4'h4) begin
			step_byte = {`EE_DEV_ADDR, 1'b1};
		end else begin
			step_byte = `EE_FIRST_OFFSET;
		end
	endfunction : step_byte

	// three-level mode pin: the pad reports floating separately
	always_comb begin
		if (pin_s.config_source_floating) begin
			mode = redriver_pkg::MODE_MASTER;
		end else if (pin_s.config_source_select) begin
			mode = redriver_pkg::MODE_SLAVE;
		end else begin
			mode = redriver_pkg::MODE_PIN;
		end
	end

	// cable detect works the same in every mode
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			low_power      <= 1'b1;
			channel_enable <= 1'b0;
			cable_prev     <= 1'b1;
		end else begin
			low_power      <= pin_s.cable_present_n;
			channel_enable <= ~pin_s.cable_present_n;
			cable_prev     <= pin_s.cable_present_n;
		end
	end

	// previous samples of the filtered bus lines for edge finding
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_prev <= pin_s.scl_in;
			sda_prev <= pin_s.sda_in;
		end
	end

	assign scl_rise  = pin_s.scl_in & ~scl_prev;
	assign scl_fall  = ~pin_s.scl_in & scl_prev;
	assign start_det = pin_s.scl_in & scl_prev & sda_prev & ~pin_s.sda_in;
	assign stop_det  = pin_s.scl_in & scl_prev & ~sda_prev & pin_s.sda_in;

	// slave write strobe lands at the acknowledge slot of a data byte
	assign sl_wr      = (mode == redriver_pkg::MODE_SLAVE) && scl_fall && sl_cnt == 4'h8
	                    && sl_state == redriver_pkg::SL_WR;
	assign sl_rd_byte = (sl_ptr < 8'(`NUM_CH)) ? cfg[sl_ptr[1:0]] : 8'h00;

	// bus slave; held idle outside slave mode so pin mode ignores the bus
	always_ff @(posedge sys_clk) begin
		if (sys_rst || mode != redriver_pkg::MODE_SLAVE) begin
			sl_state     <= redriver_pkg::SL_IDLE;
			sl_cnt       <= 4'h0;
			sl_shift     <= 8'h00;
			sl_ptr       <= 8'h00;
			sl_drive_low <= 1'b0;
			sl_acking    <= 1'b0;
		end else if (start_det) begin
			sl_state     <= redriver_pkg::SL_ADDR;
			sl_cnt       <= 4'h0;
			sl_drive_low <= 1'b0;
			sl_acking    <= 1'b0;
		end else if (stop_det) begin
			sl_state     <= redriver_pkg::SL_IDLE;
			sl_drive_low <= 1'b0;
			sl_acking    <= 1'b0;
		end else if (scl_rise) begin
			if (sl_cnt < 4'h8) begin
				sl_shift <= {sl_shift[6:0], pin_s.sda_in};
				sl_cnt   <= sl_cnt + 4'h1;
			end else begin
				sl_cnt <= 4'h0;
				// master nack ends a read, ack moves to the next byte
				if (sl_state == redriver_pkg::SL_RD && !sl_acking) begin
					if (pin_s.sda_in) begin
						sl_state <= redriver_pkg::SL_IDLE;
					end else begin
						sl_ptr <= sl_ptr + 8'h01;
					end
				end
			end
		end else if (scl_fall) begin
			if (sl_cnt == 4'h8) begin
				unique case (sl_state)
					redriver_pkg::SL_IDLE: begin
						sl_drive_low <= 1'b0;
					end
					redriver_pkg::SL_ADDR: begin
						// straps double as address bits here
						if (sl_shift[7:1] == {`SLAVE_ADDR_HI, pin_s.equalizer_strap}) begin
							sl_drive_low <= 1'b1;
							sl_acking    <= 1'b1;
							sl_state     <= sl_shift[0] ? redriver_pkg::SL_RD : redriver_pkg::SL_PTR;
						end else begin
							sl_drive_low <= 1'b0;
							sl_state     <= redriver_pkg::SL_IDLE;
						end
					end
					redriver_pkg::SL_PTR: begin
						sl_ptr       <= sl_shift;
						sl_drive_low <= 1'b1;
						sl_acking    <= 1'b1;
						sl_state     <= redriver_pkg::SL_WR;
					end
					redriver_pkg::SL_WR: begin
						sl_ptr       <= sl_ptr + 8'h01;
						sl_drive_low <= 1'b1;
						sl_acking    <= 1'b1;
					end
					redriver_pkg::SL_RD: begin
						sl_drive_low <= 1'b0;
						sl_acking    <= 1'b0;
					end
				endcase
			end else begin
				sl_acking    <= 1'b0;
				sl_drive_low <= (sl_state == redriver_pkg::SL_RD) & ~sl_rd_byte[3'h7 - sl_cnt[2:0]];
			end
		end
	end

	assign kind     = step_kind(ms_step);
	assign ms_tx    = step_byte(ms_step);
	assign ms_tick  = ms_state == redriver_pkg::MS_RUN && ms_div == 8'(`EE_QUARTER_CYCLES - 1);
	assign ee_wr    = ms_tick && ms_q == 2'h3 && kind == redriver_pkg::K_READ && ms_bit == 4'h8;
	assign load_end = ms_tick && ms_q == 2'h3 && kind == redriver_pkg::K_STOP;
	assign reload_wr = reg_req.wr && reg_req.addr == `REG_CTRL && reg_req.wdata[`CTRL_RELOAD];

	// eeprom master sequencer: four quarter ticks per bit slot
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ms_state <= redriver_pkg::MS_IDLE;
			pending  <= 1'b1;
			ms_step  <= 4'h0;
			ms_bit   <= 4'h0;
			ms_q     <= 2'h0;
			ms_div   <= 8'h00;
			ms_fail  <= 1'b0;
			ms_rx    <= 8'h00;
		end else begin
			unique case (ms_state)
				redriver_pkg::MS_IDLE: begin
					if (mode == redriver_pkg::MODE_MASTER && pending) begin
						ms_state <= redriver_pkg::MS_RUN;
						pending  <= 1'b0;
						ms_step  <= 4'h0;
						ms_bit   <= 4'h0;
						ms_q     <= 2'h0;
						ms_div   <= 8'h00;
						ms_fail  <= 1'b0;
					end
				end
				redriver_pkg::MS_RUN: begin
					if (mode != redriver_pkg::MODE_MASTER) begin
						// leaving master mode abandons the load; retry on return
						ms_state <= redriver_pkg::MS_IDLE;
						pending  <= 1'b1;
					end else if (ms_tick) begin
						ms_div <= 8'h00;
						ms_q   <= ms_q + 2'h1;
						if (ms_q == 2'h2) begin
							if (kind == redriver_pkg::K_READ && ms_bit < 4'h8) begin
								ms_rx <= {ms_rx[6:0], pin_s.sda_in};
							end
							if (kind == redriver_pkg::K_WRITE && ms_bit == 4'h8 && pin_s.sda_in) begin
								ms_fail <= 1'b1;
							end
						end
						if (ms_q == 2'h3) begin
							if (kind == redriver_pkg::K_STOP) begin
								ms_state <= redriver_pkg::MS_DONE;
							end else if (ms_bit == 4'h8 || kind == redriver_pkg::K_START) begin
								ms_bit  <= 4'h0;
								ms_step <= ms_fail ? `STEP_STOP : ms_step + 4'h1;
							end else begin
								ms_bit <= ms_bit + 4'h1;
							end
						end
					end else begin
						ms_div <= ms_div + 8'h01;
					end
				end
				redriver_pkg::MS_DONE: begin
					if (pending) begin
						ms_state <= redriver_pkg::MS_IDLE;
					end
				end
			endcase
			if (reload_wr) begin
				pending <= 1'b1;
			end
		end
	end

	// master line levels; a one on data means released
	always_comb begin
		ms_scl = 1'b1;
		ms_sda = 1'b1;
		if (ms_state == redriver_pkg::MS_RUN) begin
			ms_scl = ms_q == 2'h1 || ms_q == 2'h2;
			unique case (kind)
				redriver_pkg::K_START: begin
					ms_sda = ms_q < 2'h2;
				end
				redriver_pkg::K_STOP: begin
					ms_scl = ms_q != 2'h0;
					ms_sda = ms_q >= 2'h2;
				end
				redriver_pkg::K_WRITE: begin
					ms_sda = (ms_bit < 4'h8) ? ms_tx[3'h7 - ms_bit[2:0]] : 1'b1;
				end
				redriver_pkg::K_READ: begin
					// ack every byte but the last
					ms_sda = (ms_bit < 4'h8) ? 1'b1 : (ms_step == `STEP_LAST_READ);
				end
			endcase
		end
	end

	// serial clock is an output throughout eeprom master mode, before, during and after a load
	assign scl_oe_n = mode != redriver_pkg::MODE_MASTER;
	assign scl_out  = ms_scl;
	assign sda_out  = 1'b0;
	assign sda_oe_n = (mode == redriver_pkg::MODE_MASTER) ? ms_sda : ~sl_drive_low;

	// done output: low from reset and during a load, then the result
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			load_done <= 1'b0;
		end else if (ms_state != redriver_pkg::MS_RUN) begin
			load_done <= load_done;
		end else if (load_end) begin
			load_done <= ~ms_fail;
		end else begin
			load_done <= 1'b0;
		end
	end

	// programmable channel bytes; the reset pin outranks every writer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `NUM_CH; i++) begin
				cfg[i] <= `CH_DEFAULT;
			end
		end else if (mode != redriver_pkg::MODE_PIN && !pin_s.gain_bit1_or_reg_reset_n) begin
			for (int i = 0; i < `NUM_CH; i++) begin
				cfg[i] <= `CH_DEFAULT;
			end
		end else if (ee_wr) begin
			cfg[2'(ms_step - `STEP_FIRST_READ)] <= ms_rx;
		end else if (sl_wr && sl_ptr < 8'(`NUM_CH)) begin
			cfg[sl_ptr[1:0]] <= sl_shift;
		end
	end

	// settings seen by the analog channels, per channel flops
	genvar ch;
	generate
		for (ch = 0; ch < `NUM_CH; ch++) begin : g_ch
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					ch_setting[ch] <= '0;
				end else if (mode == redriver_pkg::MODE_PIN) begin
					ch_setting[ch].eq   <= pin_s.equalizer_strap;
					ch_setting[ch].gain <= {pin_s.gain_bit1_or_reg_reset_n,
					                        pin_s.gain_bit0_strap};
				end else begin
					ch_setting[ch].eq   <= cfg[ch][`CH_EQ_LSB +: 3];
					ch_setting[ch].gain <= cfg[ch][`CH_GAIN_LSB +: 2];
				end
			end
		end
	endgenerate

	assign events[`EV_LOAD_PASS]    = load_end & ~ms_fail;
	assign events[`EV_LOAD_FAIL]    = load_end & ms_fail;
	assign events[`EV_HOST_WRITE]   = sl_wr;
	assign events[`EV_CABLE_CHANGE] = cable_prev != pin_s.cable_present_n;

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			status <= '0;
		end else if (reg_req.wr && reg_req.addr == `REG_STATUS) begin
			status <= (status & ~reg_req.wdata[`EV_WIDTH-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	// interrupt mask
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mask <= '0;
		end else if (reg_req.wr && reg_req.addr == `REG_MASK) begin
			mask <= reg_req.wdata[`EV_WIDTH-1:0];
		end
	end

	assign irq = |(status & mask);

	// read data one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_req.rd) begin
			reg_rdata <= 32'h0000_0000;
			if (reg_req.addr == `REG_STATUS) begin
				reg_rdata[`EV_WIDTH-1:0] <= status;
			end else if (reg_req.addr == `REG_MASK) begin
				reg_rdata[`EV_WIDTH-1:0] <= mask;
			end else if (reg_req.addr == `REG_STATE) begin
				reg_rdata[`STATE_MODE_LSB +: 2] <= mode;
				reg_rdata[`STATE_LOW_POWER]     <= low_power;
				reg_rdata[`STATE_LOAD_DONE]     <= load_done;
				reg_rdata[`STATE_LOADING]       <= ms_state == redriver_pkg::MS_RUN;
			end else if (reg_req.addr[7:4] == `REG_CH_BASE >> 4 && reg_req.addr[1:0] == 2'h0) begin
				reg_rdata[`CH_EQ_LSB +: 3]   <= ch_setting[reg_req.addr[3:2]].eq;
				reg_rdata[`CH_GAIN_LSB +: 2] <= ch_setting[reg_req.addr[3:2]].gain;
			end
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule : redriver_config_source_control

// >>> tb/redriver_chk.sv
`timescale 1ns/10ps
module redriver_chk (
	input  wire logic                            sys_clk,
	input  wire logic                            sys_rst,
	input  wire redriver_pkg::reg_req_s          reg_req,
	input  wire logic                     [31:0] reg_rdata,
	input  wire redriver_pkg::pin_in_s           pins,
	input  wire logic                            scl_out,
	input  wire logic                            scl_oe_n,
	input  wire logic                            sda_out,
	input  wire logic                            sda_oe_n,
	input  wire redriver_pkg::ch_setting_s [3:0] ch_setting,
	input  wire logic                            low_power,
	input  wire logic                            channel_enable,
	input  wire logic                            load_done,
	input  wire logic                            irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// raw pad decode; eight-cycle windows absorb the synchroniser lag
	logic pin_mode;
	assign pin_mode = !pins.config_source_select && !pins.config_source_floating;

	a_enable_tracks_power: assert property (
		channel_enable == !low_power) else $error("enable is not the inverse of low power");
	a_absent_low_power: assert property (
		pins.cable_present_n [*8] |-> low_power) else $error("cable absent but not in low power");
	a_present_enabled: assert property (
		!pins.cable_present_n [*8] |-> channel_enable) else $error("cable present but disabled");
	a_scl_slave_input: assert property (
		!pins.config_source_floating [*8] |-> scl_oe_n) else $error("scl driven outside master");
	a_scl_master_drive: assert property (
		pins.config_source_floating [*8] |-> !scl_oe_n) else $error("scl not driven as master");
	a_pin_settings: assert property (
		(pin_mode && $stable(pins)) [*8] |-> ch_setting == {4{pins.equalizer_strap,
		pins.gain_bit1_or_reg_reset_n, pins.gain_bit0_strap}}) else $error("strap settings lost");
	a_reg_default: assert property (
		(!pin_mode && !pins.gain_bit1_or_reg_reset_n) [*8] |-> ch_setting == '0)
		else $error("register reset did not clear settings");
	a_done_after_stop: assert property (
		$rose(load_done) |-> !$past(scl_oe_n) && $past(sda_oe_n))
		else $error("load done rose outside a finished load");
	a_mask_clear_quiet: assert property (
		reg_req.wr && reg_req.addr == 8'h04 && reg_req.wdata[3:0] == 4'h0 |=> !irq)
		else $error("irq high with all events masked");
	a_rdata_idle: assert property (
		!reg_req.rd |=> reg_rdata == 32'h0) else $error("read data outside read slot");
endmodule : redriver_chk

bind redriver_config_source_control redriver_chk u_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
	.pins(pins), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .ch_setting(ch_setting), .low_power(low_power),
	.channel_enable(channel_enable), .load_done(load_done), .irq(irq)
);

// >>> tb/eeprom_model.sv
`timescale 1ns/10ps
module eeprom_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_rel
);
	logic [7:0] mem [4];
	logic [7:0] sh;
	logic [1:0] ptr;
	int         cnt;
	logic       act, adr, rd, mack;
	// fixed image, one byte per channel
	initial begin
		mem = '{8'h15, 8'h23, 8'h06, 8'h31};
		sda_rel = 1'b1;
		act = 1'b0;
	end
	// start restarts byte framing, stop ends the transfer
	always @(negedge sda) if (scl === 1'b1) begin
		act = 1'b1;
		adr = 1'b1;
		rd = 1'b0;
		mack = 1'b0;
		cnt = 0;
	end
	always @(posedge sda) if (scl === 1'b1) act = 1'b0;
	// bits taken while scl high; a master nack ends the read
	always @(posedge scl) if (act) begin
		if (cnt < 8) begin
			sh = {sh[6:0], sda};
			cnt++;
		end else if (mack && sda) act = 1'b0;
		else if (mack) ptr++;
	end
	// drive on the falling edge only, so data never moves under a high scl
	always @(negedge scl) begin
		if (!act) sda_rel = 1'b1;
		else if (cnt == 8) begin
			if (adr) rd = sh[0];
			else if (!rd) ptr = sh[1:0];
			mack = rd && !adr;
			sda_rel = mack;
			adr = 1'b0;
			cnt = 9;
		end else if (cnt == 9) begin
			cnt = 0;
			sda_rel = rd ? mem[ptr][7] : 1'b1;
		end else sda_rel = rd ? mem[ptr][7 - cnt] : 1'b1;
	end
endmodule : eeprom_model

// >>> tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic                            sys_clk;
	logic                            sys_rst;
	redriver_pkg::reg_req_s          req;
	redriver_pkg::pin_in_s           straps;
	redriver_pkg::pin_in_s           pin_w;
	redriver_pkg::ch_setting_s [3:0] ch;
	logic                     [31:0] rdata;
	logic                            scl_out, scl_oe_n, sda_out, sda_oe_n;
	logic                            low_power, channel_enable, load_done, irq, ee_rel;
	logic                            host_scl, host_sda;
	wire                             scl_w, sda_w;
	int                              err_count, cmp_count;

	// pulled-up bus lines: scl from the dut as master or the bench host, sda wired-and
	assign scl_w = scl_oe_n ? host_scl : scl_out;
	assign sda_w = (sda_oe_n | sda_out) & ee_rel & host_sda;
	always_comb begin
		pin_w = straps;
		pin_w.scl_in = scl_w;
		pin_w.sda_in = sda_w;
	end

	redriver_config_source_control dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata), .pins(pin_w),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.ch_setting(ch), .low_power(low_power), .channel_enable(channel_enable),
		.load_done(load_done), .irq(irq)
	);
	eeprom_model ee (.scl(scl_w), .sda(sda_w), .sda_rel(ee_rel));

	// 100 MHz
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// settle past the edge so registered outputs have landed
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : idle

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk) begin
			req.addr <= a;
			req.wdata <= d;
			req.wr <= 1'b1;
		end
		@(posedge sys_clk) req.wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe edge
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk) begin
			req.addr <= a;
			req.rd <= 1'b1;
		end
		@(posedge sys_clk) req.rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask : rd_chk

	// bench host on the slave link: 125 ns clock, idle high, data moved mid-low
	task automatic host_start;
		#31.25 host_sda <= 1'b0;
		#31.25 host_scl <= 1'b0;
	endtask : host_start

	task automatic host_stop;
		#31.25 host_sda <= 1'b0;
		#31.25 host_scl <= 1'b1;
		#31.25 host_sda <= 1'b1;
	endtask : host_stop

	// eight bits then a released ninth; ack_n is the slave's own drive mid-ninth
	task automatic host_byte(input logic [7:0] b, output logic ack_n);
		logic [8:0] s;
		s = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			#31.25 host_sda <= s[i];
			#31.25 host_scl <= 1'b1;
			#31.25 ack_n = sda_oe_n;
			#31.25 host_scl <= 1'b0;
		end
	endtask : host_byte

	task automatic t_pin_mode;
		logic [4:0] pat [2];
		pat = '{5'b10110, 5'b01001};
		foreach (pat[i]) begin
			@(posedge sys_clk) {straps.equalizer_strap, straps.gain_bit1_or_reg_reset_n,
				straps.gain_bit0_strap} <= pat[i];
			idle(8);
			for (int c = 0; c < 4; c++) chk(32'(ch[c]), 32'(pat[i]));
		end
		chk(32'(scl_oe_n), 32'h1);
	endtask : t_pin_mode

	task automatic t_cable;
		wr(8'h00, 32'hF);
		wr(8'h04, 32'h8);
		@(posedge sys_clk) straps.cable_present_n <= 1'b0;
		idle(8);
		chk(32'({channel_enable, low_power, irq}), 32'h5);
		wr(8'h00, 32'h8);
		idle(1);
		chk(32'(irq), 32'h0);
		wr(8'h04, 32'h0);
		@(posedge sys_clk) straps.cable_present_n <= 1'b1;
		idle(8);
		chk(32'({channel_enable, low_power, irq}), 32'h2);
		rd_chk(8'h00, 32'h8, 32'h8);
		wr(8'h04, 32'h8);
		idle(1);
		chk(32'(irq), 32'h1);
		wr(8'h00, 32'h8);
		rd_chk(8'h40, 32'hFFFF_FFFF, 32'h0);
		wr(8'h0C, 32'h0);
		rd_chk(8'h0C, 32'h1F, 32'h4);
	endtask : t_cable

	task automatic t_master;
		int n;
		@(posedge sys_clk) begin
			straps.config_source_floating <= 1'b1;
			straps.gain_bit1_or_reg_reset_n <= 1'b1;
		end
		idle(8);
		chk(32'({scl_oe_n, load_done}), 32'h0);
		n = 0;
		while (load_done !== 1'b1 && n < 70000) begin
			@(posedge sys_clk);
			n++;
		end
		idle(1);
		chk(32'(load_done), 32'h1);
		for (int c = 0; c < 4; c++) chk(32'(ch[c]), {ee.mem[c][2:0], ee.mem[c][5:4]});
		rd_chk(8'h00, 32'h3, 32'h1);
		rd_chk(8'h0C, 32'h1F, 32'hF);
	endtask : t_master

	task automatic t_slave;
		logic a0, a1, a2, a3;
		@(posedge sys_clk) begin
			straps.config_source_floating <= 1'b0;
			straps.config_source_select <= 1'b1;
		end
		idle(8);
		chk(32'(scl_oe_n), 32'h1);
		for (int c = 0; c < 4; c++) chk(32'(ch[c]), {ee.mem[c][2:0], ee.mem[c][5:4]});
		// straps read 010 here, so own address is 0x22: a write to 0x23 goes unanswered
		host_start();
		host_byte(8'h46, a0);
		host_stop();
		host_start();
		host_byte(8'h44, a1);
		host_byte(8'h02, a2);
		host_byte(8'h21, a3);
		host_stop();
		idle(8);
		chk(32'({a0, a1, a2, a3}), 32'h8);
		chk(32'(ch[2]), 32'h06);
		rd_chk(8'h00, 32'h4, 32'h4);
		@(posedge sys_clk) straps.gain_bit1_or_reg_reset_n <= 1'b0;
		idle(8);
		for (int c = 0; c < 4; c++) chk(32'(ch[c]), 32'h0);
		rd_chk(8'h0C, 32'h3, 32'h1);
	endtask : t_slave

	// main sequence: pads start at their pull-up levels
	initial begin
		sys_rst = 1'b1;
		req = '0;
		straps = 10'h027F;
		host_scl = 1'b1;
		host_sda = 1'b1;
		err_count = 0;
		cmp_count = 0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		idle(2);
		chk(32'({load_done, low_power}), 32'h1);
		t_pin_mode();
		t_cable();
		t_master();
		t_slave();
		tally_and_finish();
	end

	// one eeprom load is 66 bit slots of 1000 cycles; the whole run ends near 67k
	initial begin
		#1_000_000;
		err_count++;
		$display("ERROR %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : tb
